// >>> logic/nams_pkg.sv
// constants, mode type and switch decode for the address mode selector
// assumes a 100 MHz module clock and an eight-bit switch bank plus mode switch
package nams_pkg;

	////////////////////////////////////////////////////////////////////////////
	// timing
	localparam int CLK_PERIOD_NS  = 10;              // module clock period
	localparam int SETTLE_TIME_NS = 10000;           // switch settle after reset
	localparam int SETTLE_CYCLES  = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RETRY_TIME_MS  = 1000;            // request repeat period
	localparam int RETRY_CYCLES   = RETRY_TIME_MS * (1000000 / CLK_PERIOD_NS);

	////////////////////////////////////////////////////////////////////////////
	// switch bank codes with the mode switch on
	localparam logic [7:0] SW_DHCP    = 8'h01;
	localparam logic [7:0] SW_BOOTP   = 8'h02;
	localparam logic [7:0] SW_TOOL    = 8'h04;
	localparam logic [7:0] SW_UNIV    = 8'h08;
	localparam logic [7:0] SW_FRESET  = 8'h20;
	// switch bank codes with the mode switch off
	localparam logic [7:0] SW_RESTORE = 8'h00;
	localparam logic [7:0] HOST_MIN   = 8'h01;
	localparam logic [7:0] HOST_MAX   = 8'hfe;

	////////////////////////////////////////////////////////////////////////////
	// reset and default values
	localparam logic [31:0] DEFAULT_IP   = 32'hc0a801fe;
	localparam logic [31:0] DEFAULT_MASK = 32'hffffff00;

	// addressing mode chosen at start-up
	typedef enum logic [3:0] {
		MODE_NONE,
		MODE_RESTORE,
		MODE_SWITCH,
		MODE_DHCP,
		MODE_BOOTP,
		MODE_TOOL,
		MODE_UNIV,
		MODE_FRESET,
		MODE_RESERVED
	} nams_mode_t;

	// map the sampled switches to a mode
	function automatic nams_mode_t decode_mode(input logic mode_on, input logic [7:0] sw);
		nams_mode_t m;
		m = MODE_RESERVED;
		if (!mode_on) begin
			if (sw == SW_RESTORE)
				m = MODE_RESTORE;
			else if (sw >= HOST_MIN && sw <= HOST_MAX)
				m = MODE_SWITCH;
		end else begin
			unique case (sw)
				SW_DHCP:   m = MODE_DHCP;
				SW_BOOTP:  m = MODE_BOOTP;
				SW_TOOL:   m = MODE_TOOL;
				SW_UNIV:   m = MODE_UNIV;
				SW_FRESET: m = MODE_FRESET;
				default:   m = MODE_RESERVED;
			endcase
		end
		return m;
	endfunction

endpackage

// >>> logic/nams_req_if.sv
// request pacing link between the selector and its repeat timer
// assumes both ends run on the module clock
`timescale 1ns/100ps
`default_nettype none
interface nams_req_if;
	logic run;   // requests wanted
	logic tick;  // one-cycle: send a request now
	modport ctrl  (output run, input tick);
	modport timer (input run, output tick);
endinterface
`default_nettype wire

// >>> logic/nams_sync.sv
// three-stage synchroniser for the switch pins
// assumes asynchronous pins; an output moves once stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module nams_sync #(
	parameter int WIDTH = 9
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             reset_n,
	// pins and clean copy
	input  wire logic [WIDTH-1:0] pin,
	output var  logic [WIDTH-1:0] clean
);
	////////////////////////////////////////////////////////////////////////////
	logic [WIDTH-1:0] st1;        // first stage, read by st2 only
	logic [WIDTH-1:0] st2;
	logic [WIDTH-1:0] st3;
	logic [WIDTH-1:0] next_clean;

	// per-bit agreement filter
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			always_comb begin
				next_clean[i] = (st2[i] == st3[i]) ? st3[i] : clean[i];
			end
		end
	endgenerate

	// stages and filtered output
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st1   <= '0;
			st2   <= '0;
			st3   <= '0;
			clean <= '0;
		end else begin
			st1   <= pin;
			st2   <= st1;
			st3   <= st2;
			clean <= next_clean;
		end
	end
endmodule
`default_nettype wire

// >>> logic/nams_retry.sv
// repeat timer for address requests
// assumes run stays high while an answer is awaited; first tick comes at once
`timescale 1ns/100ps
`default_nettype none
module nams_retry #(
	parameter int PERIOD = 100
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic reset_n,
	// pacing link
	nams_req_if.timer req
);
	////////////////////////////////////////////////////////////////////////////
	logic [31:0] cnt;       // cycles until next tick
	logic [31:0] next_cnt;
	logic        next_tick;

	// count down while running, restart on idle
	always_comb begin
		next_cnt  = '0;
		next_tick = 1'b0;
		if (req.run) begin
			if (cnt == '0) begin
				next_tick = 1'b1;
				next_cnt  = 32'(PERIOD - 1);
			end else begin
				next_cnt = cnt - 32'h1;
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt      <= '0;
			req.tick <= 1'b0;
		end else begin
			cnt      <= next_cnt;
			req.tick <= next_tick;
		end
	end
endmodule
`default_nettype wire

// >>> logic/nams_selector.sv
// start-up address mode selector: samples switches once, forms the address
// assumes storage ports and network events are on CLK; switch pins are not
//
// Function
// RULE1 - switch address only with mode switch off
// RULE2 - switch values 1 to 254 accepted
// RULE3 - host bytes 0 and 255 never used
// RULE4 - address is sum of set switch weights
// RULE5 - other settings stay from storage
// RULE6 - switch address never written to storage
// RULE7 - switch changes ignored until next reset
// RULE8 - operator resets after changing mode
// RULE9 - mode on, value 1: DHCP address
// RULE10 - mode on, value 2: BootP address
// RULE11 - server address and mask get stored
// RULE12 - other modes load settings from storage
// RULE13 - mode on, value 4: service tool access
// RULE14 - service tool mode reads stored settings
// RULE15 - tool-assigned address stored permanently
// RULE16 - universal mode repeats DHCP until assigned
// RULE17 - universal assignment stored, client stopped
// RULE18 - universal restart with stored address: quiet
// RULE19 - factory reset restores defaults, erases flash
// RULE20 - operator picks another mode after factory reset
// RULE21 - mode on, value 8: universal mode
// RULE22 - all zero, mode off: default address
// RULE23 - sample once at reset; others reserved
`timescale 1ns/100ps
`default_nettype none
module nams_selector #(
	parameter int RETRY_CYCLES = nams_pkg::RETRY_CYCLES
) (
	// clock and reset
	input  wire logic                CLK,
	input  wire logic                RESET_N,
	// switch pins
	input  wire logic [7:0]          ADDR_SW,
	input  wire logic                MODE_SW,
	// stored settings from non-volatile storage
	input  wire logic [31:0]         NV_IP,
	input  wire logic [31:0]         NV_MASK,
	input  wire logic                NV_HAS_ADDR,
	// storage commands
	output var  logic                NV_WR,
	output var  logic [31:0]         NV_WR_IP,
	output var  logic [31:0]         NV_WR_MASK,
	output var  logic                NV_ERASE,
	// address server side
	input  wire logic                LEASE_VALID,
	input  wire logic [31:0]         LEASE_IP,
	input  wire logic [31:0]         LEASE_MASK,
	output var  logic                DHCP_REQ,
	output var  logic                BOOTP_REQ,
	// service tool side
	input  wire logic                TOOL_WR,
	input  wire logic [31:0]         TOOL_IP,
	input  wire logic [31:0]         TOOL_MASK,
	output var  logic                TOOL_ACCESS,
	// resulting configuration
	output var  nams_pkg::nams_mode_t ACTIVE_MODE,
	output var  logic [31:0]         IP_ADDR,
	output var  logic [31:0]         SUBNET_MASK,
	output var  logic                ADDR_VALID
);
	////////////////////////////////////////////////////////////////////////////
	// synchronised switches
	logic [8:0] sw_clean;    // {mode, bank}
	nams_sync #(.WIDTH(9)) u_sync (
		.clk     (CLK),
		.reset_n (RESET_N),
		.pin     ({MODE_SW, ADDR_SW}),
		.clean   (sw_clean)
	);

	// request pacing
	nams_req_if req ();
	nams_retry #(.PERIOD(RETRY_CYCLES)) u_retry (
		.clk     (CLK),
		.reset_n (RESET_N),
		.req     (req.timer)
	);

	////////////////////////////////////////////////////////////////////////////
	// control state
	typedef enum logic [1:0] {ST_SETTLE, ST_WAIT, ST_ERASE, ST_RUN} nams_state_t;
	nams_state_t          state, next_state;
	logic [15:0]          settle, next_settle;     // cycles since reset release
	nams_pkg::nams_mode_t next_mode;
	logic                 mode_on, next_mode_on;   // captured mode switch
	logic                 lease_take;              // server answer accepted
	logic                 tool_take;               // tool write accepted

	// waiting for a server answer drives the repeat timer
	assign req.run    = (state == ST_WAIT);
	// leases count while waiting, and as renewals in the pure server modes
	assign lease_take = LEASE_VALID && ((state == ST_WAIT) || (state == ST_RUN &&
		(ACTIVE_MODE == nams_pkg::MODE_DHCP || ACTIVE_MODE == nams_pkg::MODE_BOOTP)));
	// tool writes only while the tool has access
	assign tool_take  = TOOL_WR && TOOL_ACCESS;

	// sequence: settle, sample once, then act on the mode
	always_comb begin
		next_state   = state;
		next_settle  = settle;
		next_mode    = ACTIVE_MODE;
		next_mode_on = mode_on;
		unique case (state)
			ST_SETTLE: begin
				// the pins only count after they had time to pass the filter
				if (settle == 16'(nams_pkg::SETTLE_CYCLES - 1)) begin
					next_mode    = nams_pkg::decode_mode(sw_clean[8], sw_clean[7:0]); // RULE23
					next_mode_on = sw_clean[8];
					unique case (next_mode)
						nams_pkg::MODE_DHCP,
						nams_pkg::MODE_BOOTP:  next_state = ST_WAIT;              // RULE9 RULE10
						// a stored address keeps the universal client silent
						nams_pkg::MODE_UNIV:   next_state = NV_HAS_ADDR ? ST_RUN : ST_WAIT; // RULE21 RULE18
						nams_pkg::MODE_FRESET: next_state = ST_ERASE;             // RULE19
						default:               next_state = ST_RUN;
					endcase
				end else begin
					next_settle = settle + 16'h1;
				end
			end
			ST_WAIT: begin
				if (lease_take)
					next_state = ST_RUN;                                      // RULE17
			end
			ST_ERASE: next_state = ST_RUN;
			// no way back to sampling without a reset
			ST_RUN:   next_state = ST_RUN;                                    // RULE7
		endcase
	end

	// sequence registers; reset restarts the settle count and forgets the mode
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			state       <= ST_SETTLE;
			settle      <= '0;
			ACTIVE_MODE <= nams_pkg::MODE_NONE;
			mode_on     <= 1'b0;
		end else begin
			state       <= next_state;
			settle      <= next_settle;
			ACTIVE_MODE <= next_mode;
			mode_on     <= next_mode_on;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// address, storage commands and requests
	logic [31:0] next_ip, next_mask, next_wr_ip, next_wr_mask;
	logic        next_valid, next_wr, next_erase, next_dhcp, next_bootp, next_tool;

	always_comb begin
		next_ip      = IP_ADDR;
		next_mask    = SUBNET_MASK;
		next_valid   = ADDR_VALID;
		next_wr      = 1'b0;
		next_wr_ip   = NV_WR_IP;
		next_wr_mask = NV_WR_MASK;
		next_erase   = 1'b0;
		next_tool    = TOOL_ACCESS;
		// repeat requests only while an answer is awaited; the wait-state gate
		// drops a tick raised on the edge that took the lease; a tick present at that edge still goes out
		next_dhcp    = req.tick && (state == ST_WAIT) && (ACTIVE_MODE == nams_pkg::MODE_DHCP ||
			ACTIVE_MODE == nams_pkg::MODE_UNIV);                                // RULE9 RULE16 RULE17
		next_bootp   = req.tick && (state == ST_WAIT) &&
			(ACTIVE_MODE == nams_pkg::MODE_BOOTP);                              // RULE10
		if (state == ST_SETTLE && next_state != ST_SETTLE) begin
			// start from stored settings in every mode
			next_ip   = NV_IP;                                              // RULE12 RULE14
			next_mask = NV_MASK;                                            // RULE5
			unique case (next_mode)
				nams_pkg::MODE_SWITCH: begin
					// bank value is the weighted sum of its set switches
					next_ip    = {NV_IP[31:8], sw_clean[7:0]};                 // RULE1 RULE2 RULE4
					next_valid = 1'b1;                                         // RULE6
				end
				nams_pkg::MODE_RESTORE: begin
					next_ip    = nams_pkg::DEFAULT_IP;                         // RULE22
					next_mask  = nams_pkg::DEFAULT_MASK;
					next_valid = 1'b1;
				end
				nams_pkg::MODE_TOOL: begin
					next_valid = 1'b1;                                         // RULE14
					next_tool  = 1'b1;                                         // RULE13
				end
				nams_pkg::MODE_UNIV: begin
					next_valid = NV_HAS_ADDR;                                  // RULE18
					next_tool  = NV_HAS_ADDR;
				end
				nams_pkg::MODE_FRESET: begin
					next_ip    = nams_pkg::DEFAULT_IP;                         // RULE19
					next_mask  = nams_pkg::DEFAULT_MASK;
					next_erase = 1'b1;
				end
				// reserved codes, 255 among them, keep the stored address
				nams_pkg::MODE_RESERVED: next_valid = 1'b1;                  // RULE3
				default: next_valid = 1'b0;
			endcase
		end else if (state == ST_ERASE) begin
			next_valid = 1'b1;
		end else if (lease_take) begin
			// a server answer becomes the address and goes to storage
			next_ip      = LEASE_IP;
			next_mask    = LEASE_MASK;
			next_valid   = 1'b1;
			next_wr      = 1'b1;                                           // RULE11
			next_wr_ip   = LEASE_IP;
			next_wr_mask = LEASE_MASK;
			if (ACTIVE_MODE == nams_pkg::MODE_UNIV)
				next_tool = 1'b1;                                          // RULE17
		end else if (tool_take) begin
			next_ip      = TOOL_IP;
			next_mask    = TOOL_MASK;
			next_valid   = 1'b1;
			next_wr      = 1'b1;                                           // RULE15
			next_wr_ip   = TOOL_IP;
			next_wr_mask = TOOL_MASK;
		end
	end

	// output registers; the default address shows until the switches are sampled
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			IP_ADDR     <= nams_pkg::DEFAULT_IP;
			SUBNET_MASK <= nams_pkg::DEFAULT_MASK;
			ADDR_VALID  <= 1'b0;
			NV_WR       <= 1'b0;
			NV_WR_IP    <= '0;
			NV_WR_MASK  <= '0;
			NV_ERASE    <= 1'b0;
			DHCP_REQ    <= 1'b0;
			BOOTP_REQ   <= 1'b0;
			TOOL_ACCESS <= 1'b0;
		end else begin
			IP_ADDR     <= next_ip;
			SUBNET_MASK <= next_mask;
			ADDR_VALID  <= next_valid;
			NV_WR       <= next_wr;
			NV_WR_IP    <= next_wr_ip;
			NV_WR_MASK  <= next_wr_mask;
			NV_ERASE    <= next_erase;
			DHCP_REQ    <= next_dhcp;
			BOOTP_REQ   <= next_bootp;
			TOOL_ACCESS <= next_tool;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks
	// all checks sit on CLK and sleep through reset
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESET_N);

	a_mode_frozen: assert property (state == ST_RUN && $past(state) == ST_RUN |-> // RULE7
		$stable(ACTIVE_MODE) && $stable(mode_on)) else $error("mode moved after sampling");
	a_switch_range: assert property (ACTIVE_MODE == nams_pkg::MODE_SWITCH |-> // RULE2
		IP_ADDR[7:0] >= 8'h01 && IP_ADDR[7:0] <= 8'hfe) else $error("switch byte out of range");
	a_host_not_bcast: assert property (ADDR_VALID && ACTIVE_MODE != nams_pkg::MODE_RESERVED |-> // RULE3
		IP_ADDR[7:0] != 8'h00 && IP_ADDR[7:0] != 8'hff) else $error("broadcast host byte");
	a_switch_mode_off: assert property (ACTIVE_MODE == nams_pkg::MODE_SWITCH |-> !mode_on) // RULE1
		else $error("switch address with mode on");
	a_switch_no_store: assert property (ACTIVE_MODE == nams_pkg::MODE_SWITCH |-> !NV_WR) // RULE6
		else $error("switch address stored");
	a_lease_stored: assert property (state == ST_WAIT && LEASE_VALID |=> // RULE11
		NV_WR && NV_WR_IP == $past(LEASE_IP) && IP_ADDR == $past(LEASE_IP))
		else $error("lease not stored");
	a_tool_stored: assert property (TOOL_ACCESS && TOOL_WR && !LEASE_VALID |=> // RULE15
		NV_WR && NV_WR_MASK == $past(TOOL_MASK)) else $error("tool write not stored");
	a_univ_quiet: assert property (ACTIVE_MODE == nams_pkg::MODE_UNIV && state == ST_RUN // RULE18
		&& $past(state) == ST_RUN |-> !DHCP_REQ) else $error("universal mode still requesting");
	a_dhcp_req_src: assert property (DHCP_REQ |-> $past(state) == ST_WAIT && // RULE16
		(ACTIVE_MODE == nams_pkg::MODE_DHCP || ACTIVE_MODE == nams_pkg::MODE_UNIV))
		else $error("stray dhcp request");
	a_bootp_req_src: assert property (BOOTP_REQ |-> ACTIVE_MODE == nams_pkg::MODE_BOOTP) // RULE10
		else $error("stray bootp request");
	a_tool_gate: assert property (TOOL_ACCESS |-> ACTIVE_MODE == nams_pkg::MODE_TOOL // RULE13
		|| ACTIVE_MODE == nams_pkg::MODE_UNIV) else $error("tool access in wrong mode");
	a_erase_first: assert property ($rose(ADDR_VALID) && ACTIVE_MODE == nams_pkg::MODE_FRESET // RULE19
		|-> $past(NV_ERASE) && IP_ADDR == nams_pkg::DEFAULT_IP) else $error("reset without erase");
	a_restore_dflt: assert property (ACTIVE_MODE == nams_pkg::MODE_RESTORE && ADDR_VALID // RULE22
		|-> IP_ADDR == nams_pkg::DEFAULT_IP) else $error("restore without default address");

	// pulses stand one cycle; a late request after a lease would confuse the server
	a_req_single: assert property (DHCP_REQ |=> !DHCP_REQ) // RULE16
		else $error("dhcp request longer than one cycle");
	a_erase_once: assert property (NV_ERASE |=> !NV_ERASE && ADDR_VALID) // RULE19
		else $error("erase pulse not followed by valid address");
	a_tool_no_req: assert property (ACTIVE_MODE == nams_pkg::MODE_TOOL |-> // RULE14
		!DHCP_REQ && !BOOTP_REQ) else $error("request in service tool mode");
	a_univ_stopped: assert property (ACTIVE_MODE == nams_pkg::MODE_UNIV && TOOL_ACCESS && // RULE17
		$past(TOOL_ACCESS) |-> !DHCP_REQ) else $error("universal client not stopped");

	// coverage of the main start-up paths
	c_dhcp_lease: cover property (ACTIVE_MODE == nams_pkg::MODE_DHCP && NV_WR);
	c_univ_quiet: cover property (ACTIVE_MODE == nams_pkg::MODE_UNIV && TOOL_ACCESS && !NV_WR);
	c_tool_write: cover property (ACTIVE_MODE == nams_pkg::MODE_TOOL && NV_WR);
	c_freset:     cover property (NV_ERASE);
	c_switch_addr: cover property (ACTIVE_MODE == nams_pkg::MODE_SWITCH && ADDR_VALID);
endmodule
`default_nettype wire

// >>> bench/nams_server.sv
// address server stand-in: answers dhcp or bootp requests with a lease
// assumes one-cycle request pulses on the module clock; drives on the falling edge
`timescale 1ns/100ps
`default_nettype none
module nams_server (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        reset_n,
	// requests from the selector
	input  wire logic        dhcp_req,
	input  wire logic        bootp_req,
	// behaviour chosen by the bench
	input  wire logic        answer,
	input  wire logic [15:0] delay,
	input  wire logic [31:0] ip,
	input  wire logic [31:0] mask,
	// lease towards the selector
	output var  logic        lease_valid,
	output var  logic [31:0] lease_ip,
	output var  logic [31:0] lease_mask
);
	logic [15:0] wait_cnt; // cycles left before the answer

	////////////////////////////////////////////////////////////////////////////
	// one lease per request; requests seen while busy are dropped, like a slow server
	always @(negedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wait_cnt    = 16'h0000;
			lease_valid = 1'b0;
			lease_ip    = 32'h00000000;
			lease_mask  = 32'h00000000;
		end else begin
			// data toggles outside a lease so a stale value is never mistaken
			lease_valid = 1'b0;
			lease_ip    = ~lease_ip;
			lease_mask  = ~lease_mask;
			if (wait_cnt == 16'h0001) begin
				lease_valid = 1'b1;
				lease_ip    = ip;
				lease_mask  = mask;
			end
			if (wait_cnt != 16'h0000)
				wait_cnt = wait_cnt - 16'h0001;
			else if (answer && (dhcp_req || bootp_req))
				wait_cnt = delay;
		end
	end
endmodule
`default_nettype wire

// >>> bench/tb.sv
// self-checking bench for the start-up address mode selector
// assumes the selector samples its switches SETTLE_CYCLES edges after reset
`timescale 1ns/100ps
`default_nettype none
module tb;
	localparam int          RC  = 20;           // short request period
	localparam logic [31:0] NIP = 32'h0a141e28; // stored address
	localparam logic [31:0] NMK = 32'hffff0000; // stored mask
	localparam logic [31:0] SIP = 32'h0a000107; // server lease
	localparam logic [31:0] TIP = 32'h0a0002c8; // tool address

	// design inputs
	logic        clk, reset_n, mode_sw, nv_has, tool_wr, answer;
	logic [7:0]  addr_sw;
	logic [15:0] delay;
	logic [31:0] nv_ip, nv_mask, tool_ip, tool_mask;
	// design outputs
	logic        nv_wr, nv_erase, dhcp_req, bootp_req, tool_access, addr_valid;
	logic        lease_valid;
	logic [31:0] nv_wr_ip, nv_wr_mask, ip_addr, subnet_mask, lease_ip, lease_mask;
	nams_pkg::nams_mode_t active_mode;
	// bookkeeping
	int          n_mismatch, tests_run, n_dhcp, n_bootp, n_wr, n_erase, d0, b0, w0, e0, k;
	logic [7:0]  sw_tab [3] = '{8'h01, 8'h32, 8'hfe};

	nams_selector #(.RETRY_CYCLES(RC)) i_nams_selector (
		.CLK(clk), .RESET_N(reset_n), .ADDR_SW(addr_sw), .MODE_SW(mode_sw),
		.NV_IP(nv_ip), .NV_MASK(nv_mask), .NV_HAS_ADDR(nv_has), .NV_WR(nv_wr),
		.NV_WR_IP(nv_wr_ip), .NV_WR_MASK(nv_wr_mask), .NV_ERASE(nv_erase),
		.LEASE_VALID(lease_valid), .LEASE_IP(lease_ip), .LEASE_MASK(lease_mask),
		.DHCP_REQ(dhcp_req), .BOOTP_REQ(bootp_req), .TOOL_WR(tool_wr),
		.TOOL_IP(tool_ip), .TOOL_MASK(tool_mask), .TOOL_ACCESS(tool_access),
		.ACTIVE_MODE(active_mode), .IP_ADDR(ip_addr), .SUBNET_MASK(subnet_mask),
		.ADDR_VALID(addr_valid));

	nams_server i_nams_server (
		.clk(clk), .reset_n(reset_n), .dhcp_req(dhcp_req), .bootp_req(bootp_req),
		.answer(answer), .delay(delay), .ip(SIP), .mask(NMK),
		.lease_valid(lease_valid), .lease_ip(lease_ip), .lease_mask(lease_mask));

	////////////////////////////////////////////////////////////////////////////
	// clock and pulse counters
	always #5 clk = ~clk;
	always @(posedge clk) begin
		n_dhcp  += (dhcp_req === 1'b1);
		n_bootp += (bootp_req === 1'b1);
		n_wr    += (nv_wr === 1'b1);
		n_erase += (nv_erase === 1'b1);
	end

	////////////////////////////////////////////////////////////////////////////
	// compare tasks
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chk_mode(input nams_pkg::nams_mode_t exp);
		tests_run++;
		if (active_mode !== exp) begin
			n_mismatch++;
			$display("[FAIL] mode expected %0d seen %0d", exp, active_mode);
		end
	endtask

	////////////////////////////////////////////////////////////////////////////
	// power-on reset with new switch settings; returns after the sample edge
	task automatic power_up(input logic m, input logic [7:0] sw, input logic has);
		@(negedge clk);
		reset_n = 1'b0;
		mode_sw = m;
		addr_sw = sw;
		nv_has  = has;
		repeat (10) @(negedge clk);
		reset_n = 1'b1;
		repeat (nams_pkg::SETTLE_CYCLES) @(posedge clk);
		@(negedge clk);
		d0 = n_dhcp;
		b0 = n_bootp;
		w0 = n_wr;
		e0 = n_erase;
	endtask
	// one tool assignment; the store pulse shows at the next edge
	task automatic tool_write(input logic [31:0] ip, input logic [31:0] mask);
		tool_wr   = 1'b1;
		tool_ip   = ip;
		tool_mask = mask;
		@(negedge clk);
		tool_wr   = 1'b0;
		tool_ip   = ~ip;
		tool_mask = ~mask;
	endtask
	// bounded wait for a store pulse
	task automatic wait_wr;
		k = 0;
		while (nv_wr !== 1'b1 && k < 500) begin
			@(negedge clk);
			k++;
		end
		chk("store pulse", 32'h1, {31'h0, nv_wr});
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////
	// watchdog: the whole run needs about 12600 cycles
	initial begin
		#300us;
		n_mismatch++;
		report_and_stop();
	end

	////////////////////////////////////////////////////////////////////////////
	// test sequence; every mode change goes through a power-on reset
	initial begin
		{clk, reset_n, mode_sw, nv_has, tool_wr, answer, addr_sw, delay} = '0;
		{n_mismatch, tests_run, n_dhcp, n_bootp, n_wr, n_erase} = '0;
		nv_ip     = NIP;
		nv_mask   = NMK;
		tool_ip   = 32'h0;
		tool_mask = 32'h0;
		// switch addressing at the edges of the range and a mid value
		foreach (sw_tab[i]) begin
			power_up(1'b0, sw_tab[i], 1'b0);
			chk_mode(nams_pkg::MODE_SWITCH);
			chk("switch ip", {NIP[31:8], sw_tab[i]}, ip_addr);
			chk("switch mask", NMK, subnet_mask);
			chk("switch valid", 32'h1, {31'h0, addr_valid});
			addr_sw = ~sw_tab[i];
			mode_sw = 1'b1;
			tool_write(TIP, NMK);
			repeat (3 * RC) @(negedge clk);
			chk("switch held", {NIP[31:8], sw_tab[i]}, ip_addr);
			chk("switch stores", w0, n_wr);
		end
		$display("test switch done");
		// broadcast value refused, all-zero gives the default address
		power_up(1'b0, 8'hff, 1'b0);
		chk_mode(nams_pkg::MODE_RESERVED);
		chk("no broadcast ip", NIP, ip_addr);
		power_up(1'b0, 8'h00, 1'b0);
		chk_mode(nams_pkg::MODE_RESTORE);
		chk("default ip", nams_pkg::DEFAULT_IP, ip_addr);
		chk("default mask", nams_pkg::DEFAULT_MASK, subnet_mask);
		$display("test restore done");
		// prompt server for dhcp then bootp
		for (int i = 0; i < 2; i++) begin
			answer = 1'b1;
			delay  = 16'h0003;
			power_up(1'b1, i ? nams_pkg::SW_BOOTP : nams_pkg::SW_DHCP, 1'b0);
			chk_mode(i ? nams_pkg::MODE_BOOTP : nams_pkg::MODE_DHCP);
			wait_wr();
			chk("stored ip", SIP, nv_wr_ip);
			chk("stored mask", NMK, nv_wr_mask);
			chk("lease ip", SIP, ip_addr);
			chk("dhcp count", i ? 0 : 1, n_dhcp - d0);
			chk("bootp count", i ? 1 : 0, n_bootp - b0);
		end
		$display("test server done");
		// universal mode with a slow server, then a restart with an address stored
		delay = 16'd45;
		power_up(1'b1, nams_pkg::SW_UNIV, 1'b0);
		chk_mode(nams_pkg::MODE_UNIV);
		wait_wr();
		chk("univ ip", SIP, nv_wr_ip);
		chk("univ retries", 32'h1, {31'h0, (n_dhcp - d0) >= 2});
		answer = 1'b0;
		repeat (2) @(negedge clk);
		d0 = n_dhcp;
		repeat (3 * RC) @(negedge clk);
		chk("univ stopped", d0, n_dhcp);
		chk("univ access", 32'h1, {31'h0, tool_access});
		power_up(1'b1, nams_pkg::SW_UNIV, 1'b1);
		repeat (3 * RC) @(negedge clk);
		chk("univ quiet", d0, n_dhcp);
		chk("univ nv ip", NIP, ip_addr);
		$display("test universal done");
		// service tool mode reads storage, stores a tool address
		power_up(1'b1, nams_pkg::SW_TOOL, 1'b0);
		chk_mode(nams_pkg::MODE_TOOL);
		chk("tool access", 32'h1, {31'h0, tool_access});
		chk("tool nv ip", NIP, ip_addr);
		chk("tool nv mask", NMK, subnet_mask);
		tool_write(TIP, 32'hffffff00);
		chk("tool store", 32'h1, {31'h0, nv_wr});
		chk("tool stored ip", TIP, nv_wr_ip);
		chk("tool stored mask", 32'hffffff00, nv_wr_mask);
		chk("tool ip", TIP, ip_addr);
		chk("tool mask", 32'hffffff00, subnet_mask);
		$display("test tool done");
		// factory reset and a reserved code
		power_up(1'b1, nams_pkg::SW_FRESET, 1'b0);
		repeat (5) @(negedge clk);
		chk_mode(nams_pkg::MODE_FRESET);
		chk("erase count", 1, n_erase - e0);
		chk("freset ip", nams_pkg::DEFAULT_IP, ip_addr);
		chk("freset valid", 32'h1, {31'h0, addr_valid});
		power_up(1'b1, 8'h10, 1'b0);
		repeat (3 * RC) @(negedge clk);
		chk_mode(nams_pkg::MODE_RESERVED);
		chk("reserved quiet", d0 + b0, n_dhcp + n_bootp);
		$display("test factory done");
		report_and_stop();
	end
endmodule
`default_nettype wire
